// ===== rtl/ptm_timer.v
// Summary of operation
// - Polarity bit inverts pin, except timer and capture modes.
// - Capture source: 0 timer pin, 1 count pin.
// - Clear select 1 clears on A match.
// - Zero period value gives full-range overflow.
// - Clear select ignored outside compare/timer modes.
// - Counter readable as low and high bytes.
// - High bytes bits 7 to 2 read zero.
// - Duty compare value held in two registers.
// - Period compare value held in two registers.
// - Two-bit mode field selects operating mode.
// - Compare mode, clear select 0: both flags.
// - Compare mode, clear select 1: A flag only.
// - Compare pin changes only on A match and enable rise.
// - Period match never moves the compare pin.
// - Enable rising edge loads initial pin level.
// - Timer mode counts like compare, no pin.
// - PWM period clears counter, duty from A.
// - PWM sets both flags on matches.
// - PWM level, force and inversion controls.
// - Duty at or above period gives 100%.
// - PWM counting continues while pin forced.
// - Enable rise zeroes counter, fall holds it.
// - Pause freezes counter, release resumes.
// - Three-bit field selects the count clock.
// - Compare A match: none, low, high, toggle.

`include "ptm_map.vh"

`default_nettype none

module ptm_timer (
   input wire clk_i,
   input wire rst_b_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire fh_tick_i,
   input wire tbc_tick_i,
   input wire ext_count_pin_i,
   input wire timer_io_pin_i,
   output reg timer_io_pin_o,
   output reg timer_io_pin_oe_o,
   output reg match_a_flag_o,
   output reg match_p_flag_o
);

   // Software visible state.
   reg counter_pause;
   reg [2:0] clk_sel;
   reg counter_enable;
   reg [1:0] op_mode;
   reg [1:0] out_func;
   reg out_initial_level;
   reg output_invert;
   reg capture_source_sel;
   reg clear_source_sel;
   reg [9:0] duty_compare_value;
   reg [9:0] period_compare_value;
   reg [9:0] count;

   // Internal state.
   reg enable_prev;
   reg [1:0] sys_div;
   reg [5:0] fh_div;
   reg ext_prev;
   reg cap_prev;
   reg out_level;

   // Reset images of the two control registers; each field takes its own slice.
   localparam [7:0] rst_c0 = `PTM_RST_CTRL0;
   localparam [7:0] rst_c1 = `PTM_RST_CTRL1;

   wire ext_sync;
   wire io_sync;

   // Synchronise the two pins before any logic looks at them.
   ptm_sync u_sync_ext (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i(ext_count_pin_i),
      .q_o(ext_sync)
   );

   ptm_sync u_sync_io (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i(timer_io_pin_i),
      .q_o(io_sync)
   );

   // Mode decode.
   wire mode_cmp = (op_mode == `PTM_MODE_CMP);
   wire mode_tmr = (op_mode == `PTM_MODE_TMR);
   wire mode_cap = (op_mode == `PTM_MODE_CAP);
   wire mode_pwm = (op_mode == `PTM_MODE_PWM) && (out_func != `PTM_FN_11);
   wire mode_spl = (op_mode == `PTM_MODE_PWM) && (out_func == `PTM_FN_11);
   wire cmp_like = mode_cmp || mode_tmr;

   // Edges of the synchronised pins and of the enable bit.
   wire ext_rise = ext_sync && !ext_prev;
   wire ext_fall = !ext_sync && ext_prev;
   wire cap_src = capture_source_sel ? ext_sync : io_sync;
   wire cap_rise = cap_src && !cap_prev;
   wire cap_fall = !cap_src && cap_prev;
   wire enable_rise = counter_enable && !enable_prev;

   // Count clock selection among the internal and pin sources.
   reg tick;
   always @* begin
      case (clk_sel)
         `PTM_CK_SYS4: tick = (sys_div == `PTM_SYS4_LAST);
         `PTM_CK_SYS: tick = 1'b1;
         `PTM_CK_H16: tick = fh_tick_i && ({2'h0, fh_div[3:0]} == `PTM_H16_LAST);
         `PTM_CK_H64: tick = fh_tick_i && (fh_div == `PTM_H64_LAST);
         `PTM_CK_TBC: tick = tbc_tick_i;
         `PTM_CK_H: tick = fh_tick_i;
         `PTM_CK_EXTR: tick = ext_rise;
         default: tick = ext_fall;
      endcase
   end

   // The counter advances once per event while enabled and not paused.
   wire run_tick = tick && counter_enable && !counter_pause && !enable_rise;
   wire [9:0] next_count = count + 10'h001;

   // A zero period value matches on the wrap to zero, i.e. on overflow.
   wire match_a = run_tick && (next_count == duty_compare_value);
   wire match_p = run_tick && (next_count == period_compare_value);

   // Clear source depends on mode; clear select only counts in compare and timer modes.
   wire clr_now = cmp_like ? (clear_source_sel ? match_a : match_p)
                           : ((mode_pwm || mode_cap) && match_p);

   // Capture events, with the edge type chosen by the output function field.
   wire cap_event = mode_cap && counter_enable &&
                    (((out_func == `PTM_FN_00) && cap_rise) ||
                     ((out_func == `PTM_FN_01) && cap_fall) ||
                     ((out_func == `PTM_FN_10) && (cap_rise || cap_fall)));

   // Flag set conditions.
   wire set_a = match_a || cap_event;
   wire set_p = match_p && !mode_spl && !(cmp_like && clear_source_sel);

   // Bus strobes decoded per register.
   wire wr_c0 = wr_i && (addr_i == `PTM_OFS_CTRL0);
   wire wr_c1 = wr_i && (addr_i == `PTM_OFS_CTRL1);
   wire wr_fl = wr_i && (addr_i == `PTM_OFS_FLAGS);

   // Prescalers for the divided system and high clocks.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_div <= 2'h0;
         fh_div <= 6'h00;
      end else begin
         sys_div <= sys_div + 2'h1;
         if (fh_tick_i) begin
            fh_div <= fh_div + 6'h01;
         end
      end
   end

   // Control register zero; the enable bit also moves in single pulse mode.
   // A bus write in the same cycle as a pin trigger wins, so software can always stop a pulse.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         counter_pause <= rst_c0[`PTM_C0_PAUSE];
         clk_sel <= rst_c0[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO];
         counter_enable <= rst_c0[`PTM_C0_ENABLE];
      end else begin
         if (wr_c0) begin
            counter_pause <= wdata_i[`PTM_C0_PAUSE];
            clk_sel <= wdata_i[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO];
            counter_enable <= wdata_i[`PTM_C0_ENABLE];
         end else if (mode_spl && ext_rise) begin
            counter_enable <= 1'b1;
         end else if (mode_spl && match_a) begin
            counter_enable <= 1'b0;
         end
      end
   end

   // Control register one.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_mode <= rst_c1[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
         out_func <= rst_c1[`PTM_C1_FUNC_HI:`PTM_C1_FUNC_LO];
         out_initial_level <= rst_c1[`PTM_C1_INIT];
         output_invert <= rst_c1[`PTM_C1_INVERT];
         capture_source_sel <= rst_c1[`PTM_C1_CAPSRC];
         clear_source_sel <= rst_c1[`PTM_C1_CLRSEL];
      end else if (wr_c1) begin
         op_mode <= wdata_i[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
         out_func <= wdata_i[`PTM_C1_FUNC_HI:`PTM_C1_FUNC_LO];
         out_initial_level <= wdata_i[`PTM_C1_INIT];
         output_invert <= wdata_i[`PTM_C1_INVERT];
         capture_source_sel <= wdata_i[`PTM_C1_CAPSRC];
         clear_source_sel <= wdata_i[`PTM_C1_CLRSEL];
      end
   end

   // Compare values; a capture event loads the counter into the duty value.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         duty_compare_value <= `PTM_RST_CMP;
         period_compare_value <= `PTM_RST_CMP;
      end else begin
         if (cap_event) begin
            duty_compare_value <= count;
         end else if (wr_i && (addr_i == `PTM_OFS_DUTY_LO)) begin
            duty_compare_value[7:0] <= wdata_i;
         end else if (wr_i && (addr_i == `PTM_OFS_DUTY_HI)) begin
            duty_compare_value[9:8] <= wdata_i[1:0];
         end
         if (wr_i && (addr_i == `PTM_OFS_PER_LO)) begin
            period_compare_value[7:0] <= wdata_i;
         end else if (wr_i && (addr_i == `PTM_OFS_PER_HI)) begin
            period_compare_value[9:8] <= wdata_i[1:0];
         end
      end
   end

   // Counter and edge history registers.
   // The cycle of the enable rise only zeroes the count, so the first tick after it gives one.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count <= 10'h000;
         enable_prev <= 1'b0;
         ext_prev <= 1'b0;
         cap_prev <= 1'b0;
      end else begin
         enable_prev <= counter_enable;
         ext_prev <= ext_sync;
         cap_prev <= cap_src;
         if (enable_rise) begin
            count <= 10'h000;
         end else if (run_tick) begin
            count <= clr_now ? 10'h000 : next_count;
         end
      end
   end

   // Sticky match flags; a set in the same cycle as a clear wins.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         match_a_flag_o <= 1'b0;
         match_p_flag_o <= 1'b0;
      end else begin
         match_a_flag_o <= set_a || (match_a_flag_o && !(wr_fl && wdata_i[`PTM_FL_A]));
         match_p_flag_o <= set_p || (match_p_flag_o && !(wr_fl && wdata_i[`PTM_FL_P]));
      end
   end

   // Period value widened so that zero stands for the full 1024 count.
   wire [10:0] period_full = (period_compare_value == 10'h000) ? 11'h400 : {1'b0, period_compare_value};

   // PWM is active from each clear until the duty match, or always at full duty.
   // The level is taken from the counter itself, so the registered pin trails it by one cycle.
   wire pwm_active = ({1'b0, duty_compare_value} >= period_full) ||
                     (count < duty_compare_value);

   // Compare mode level: loaded on enable rise, acted on only by A matches.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_level <= 1'b0;
      end else if (enable_rise) begin
         out_level <= out_initial_level;
      end else if (mode_cmp && match_a) begin
         case (out_func)
            `PTM_FN_01: out_level <= 1'b0;
            `PTM_FN_10: out_level <= 1'b1;
            `PTM_FN_11: out_level <= !out_level;
            default: out_level <= out_level;
         endcase
      end
   end

   // Pin level before inversion for the modes that drive the pin.
   reg raw_pin;
   always @* begin
      raw_pin = out_level;
      if (mode_pwm) begin
         case (out_func)
            `PTM_FN_00: raw_pin = !out_initial_level;
            `PTM_FN_01: raw_pin = out_initial_level;
            default: raw_pin = pwm_active ? out_initial_level : !out_initial_level;
         endcase
      end else if (mode_spl) begin
         raw_pin = counter_enable ? out_initial_level : !out_initial_level;
      end
   end

   // Pin output register; timer and capture modes release the pin.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         timer_io_pin_o <= 1'b0;
         timer_io_pin_oe_o <= 1'b0;
      end else begin
         timer_io_pin_oe_o <= !mode_tmr && !mode_cap;
         if (!mode_tmr && !mode_cap) begin
            timer_io_pin_o <= raw_pin ^ output_invert;
         end
      end
   end

   // Read data, registered one cycle after the read strobe.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         if (addr_i == `PTM_OFS_CTRL0) begin
            rdata_o <= {counter_pause, clk_sel, counter_enable, 3'h0};
         end else if (addr_i == `PTM_OFS_CTRL1) begin
            rdata_o <= {op_mode, out_func, out_initial_level, output_invert,
                        capture_source_sel, clear_source_sel};
         end else if (addr_i == `PTM_OFS_CNT_LO) begin
            rdata_o <= count[7:0];
         end else if (addr_i == `PTM_OFS_CNT_HI) begin
            rdata_o <= {6'h00, count[9:8]};
         end else if (addr_i == `PTM_OFS_DUTY_LO) begin
            rdata_o <= duty_compare_value[7:0];
         end else if (addr_i == `PTM_OFS_DUTY_HI) begin
            rdata_o <= {6'h00, duty_compare_value[9:8]};
         end else if (addr_i == `PTM_OFS_PER_LO) begin
            rdata_o <= period_compare_value[7:0];
         end else if (addr_i == `PTM_OFS_PER_HI) begin
            rdata_o <= {6'h00, period_compare_value[9:8]};
         end else if (addr_i == `PTM_OFS_FLAGS) begin
            rdata_o <= {6'h00, match_p_flag_o, match_a_flag_o};
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

endmodule

`default_nettype wire

// ===== rtl/ptm_map.vh
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

// Register byte offsets on the register port.
`define PTM_OFS_CTRL0 4'h0
`define PTM_OFS_CTRL1 4'h1
`define PTM_OFS_CNT_LO 4'h2
`define PTM_OFS_CNT_HI 4'h3
`define PTM_OFS_DUTY_LO 4'h4
`define PTM_OFS_DUTY_HI 4'h5
`define PTM_OFS_PER_LO 4'h6
`define PTM_OFS_PER_HI 4'h7
`define PTM_OFS_FLAGS 4'h8

// Control register zero field positions.
`define PTM_C0_PAUSE 7
`define PTM_C0_CKSEL_HI 6
`define PTM_C0_CKSEL_LO 4
`define PTM_C0_ENABLE 3

// Control register one field positions.
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_FUNC_HI 5
`define PTM_C1_FUNC_LO 4
`define PTM_C1_INIT 3
`define PTM_C1_INVERT 2
`define PTM_C1_CAPSRC 1
`define PTM_C1_CLRSEL 0

// Flag register field positions.
`define PTM_FL_A 0
`define PTM_FL_P 1

// Reset values.
`define PTM_RST_CTRL0 8'h00
`define PTM_RST_CTRL1 8'h00
`define PTM_RST_CMP 10'h000

// Operating modes.
`define PTM_MODE_CMP 2'h0
`define PTM_MODE_CAP 2'h1
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3

// Output function codes.
`define PTM_FN_00 2'h0
`define PTM_FN_01 2'h1
`define PTM_FN_10 2'h2
`define PTM_FN_11 2'h3

// Clock select codes.
`define PTM_CK_SYS4 3'h0
`define PTM_CK_SYS 3'h1
`define PTM_CK_H16 3'h2
`define PTM_CK_H64 3'h3
`define PTM_CK_TBC 3'h4
`define PTM_CK_H 3'h5
`define PTM_CK_EXTR 3'h6
`define PTM_CK_EXTF 3'h7

// Prescaler terminal counts.
`define PTM_SYS4_LAST 2'h3
`define PTM_H16_LAST 6'h0f
`define PTM_H64_LAST 6'h3f

`endif

// ===== rtl/ptm_sync.v
`default_nettype none

// Two flip-flop synchroniser for one asynchronous level.
module ptm_sync (
   input wire clk_i,
   input wire rst_b_i,
   input wire d_i,
   output reg q_o
);

   reg stage1;

   // Only the second stage is visible outside this module.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= 1'b0;
         q_o <= 1'b0;
      end else begin
         stage1 <= d_i;
         q_o <= stage1;
      end
   end

endmodule

`default_nettype wire

// ===== tb/ptm_timer_sva.sv
`default_nettype none
module ptm_timer_sva (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic timer_io_pin_o,
   input wire logic timer_io_pin_oe_o,
   input wire logic match_a_flag_o,
   input wire logic match_p_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh [0:7];
   wire [1:0] mode = sh[1][7:6];

   // Shadow copies of the control and compare bytes, rebuilt from bus writes.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sh <= '{default: 8'h00};
      end else if (wr_i && addr_i < 4'h8) begin
         sh[addr_i[2:0]] <= wdata_i;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Settled configurations; a mode must hold for a few cycles before its pin effect is due.
   sequence s_tmr_set;
      (mode == 2'h3) [*2];
   endsequence
   sequence s_cmp_clr_a;
      (mode == 2'h0 && sh[1][0]) [*2];
   endsequence
   sequence s_pwm_forced;
      (mode == 2'h2 && !sh[1][5] && sh[0][3]) [*4];
   endsequence

   a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (rd_i && addr_i > 4'h8 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_period_lo_back: assert property (rd_i && addr_i == 4'h6 |=> rdata_o == $past(sh[6]))
      else $error("period low byte readback wrong");
   a_period_hi_back: assert property (rd_i && addr_i == 4'h7 |=> rdata_o == {6'h00, $past(sh[7][1:0])})
      else $error("period high byte readback wrong");
   a_duty_lo_back: assert property (rd_i && addr_i == 4'h4 && mode != 2'h1 |=> rdata_o == $past(sh[4]))
      else $error("duty low byte readback wrong");
   a_timer_no_drive: assert property (s_tmr_set |-> !timer_io_pin_oe_o)
      else $error("pin driven in timer mode");
   a_no_p_flag: assert property (s_cmp_clr_a |-> !$rose(match_p_flag_o))
      else $error("period flag set with duty clear");
   a_flag_sticky: assert property (match_a_flag_o && !(wr_i && addr_i == 4'h8) |=> match_a_flag_o)
      else $error("duty flag dropped without clear");
   a_pwm_forced: assert property (s_pwm_forced |-> timer_io_pin_o == ~^sh[1][4:2])
      else $error("forced pwm level wrong");
endmodule

bind ptm_timer ptm_timer_sva ptm_timer_sva_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_io_pin_o(timer_io_pin_o),
   .timer_io_pin_oe_o(timer_io_pin_oe_o), .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));
`default_nettype wire

// ===== tb/tb_periodic_timer_compare_pwm.sv
`default_nettype none
module tb_periodic_timer_compare_pwm;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic fh_tick_i = 1'b1;
   logic tbc_tick_i = 1'b0;
   logic ext_count_pin_i = 1'b0;
   logic timer_io_pin_i = 1'b0;
   logic [1:0] ph = 2'h0;
   logic [7:0] rdata_o;
   logic timer_io_pin_o, timer_io_pin_oe_o, match_a_flag_o, match_p_flag_o;
   integer fails = 0;
   integer tests_run = 0;

   ptm_timer ptm_timer_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .fh_tick_i(fh_tick_i), .tbc_tick_i(tbc_tick_i),
      .ext_count_pin_i(ext_count_pin_i), .timer_io_pin_i(timer_io_pin_i), .timer_io_pin_o(timer_io_pin_o),
      .timer_io_pin_oe_o(timer_io_pin_oe_o), .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));

   // The 40 MHz clock.
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // Time-base ticks every second cycle; the count pin rises every eighth.
   always @(posedge clk_i) begin
      tbc_tick_i <= ~tbc_tick_i;
      ph <= ph + 2'h1;
      if (ph == 2'h3) ext_count_pin_i <= ~ext_count_pin_i;
   end

   // Compares one result and counts it.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand in the cycle after the strobe, so they are taken just past that edge.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   // Stops the timer, loads the set-up, clears both flags and rewrites control zero with c0.
   task automatic setup(input logic [7:0] c0, c1, du, pe);
      wr(4'h0, 8'h00);
      wr(4'h1, c1);
      wr(4'h4, du);
      wr(4'h5, 8'h00);
      wr(4'h6, pe);
      wr(4'h7, 8'h00);
      wr(4'h8, 8'h03);
      wr(4'h0, c0);
   endtask

   task automatic t_regs;
      logic [7:0] d;
      for (int a = 2; a < 8; a++) begin
         rd(a[3:0], d);
         chk(d, 8'h00);
      end
      rd(4'hf, d);
      chk(d, 8'h00);
      for (int a = 2; a < 8; a++) wr(a[3:0], 8'hff);
      for (int a = 2; a < 8; a++) begin
         rd(a[3:0], d);
         chk(d, (a < 4) ? 8'h00 : (a[0] ? 8'h03 : 8'hff));
      end
      $display("register test done");
   endtask

   // Compare output: every output function, odd codes with inversion and even codes without.
   task automatic t_cmp;
      logic [7:0] d;
      logic ini, inv;
      for (int f = 0; f < 4; f++) begin
         ini = (f < 2);
         inv = f[0];
         setup(8'h18, {2'h0, f[1:0], ini, inv, 2'h0}, 8'h08, 8'h00);
         cyc(5);
         chk(timer_io_pin_o, ini ^ inv);
         cyc(30);
         chk({timer_io_pin_oe_o, match_a_flag_o, timer_io_pin_o}, {2'h3, (f != 1) ^ inv});
         rd(4'h2, d);
         chk(d > 8'h08, 1'b1);
      end
      setup(8'h18, 8'h20, 8'h08, 8'd4);
      cyc(40);
      chk({match_a_flag_o, match_p_flag_o, timer_io_pin_o}, 3'h2);
      $display("compare output test done");
   endtask

   task automatic clr(input logic [7:0] c1, pe, input logic p, oe, input logic [7:0] lim);
      logic [7:0] d;
      setup(8'h18, c1, 8'h08, pe);
      cyc(40);
      rd(4'h2, d);
      chk({match_a_flag_o, match_p_flag_o, timer_io_pin_oe_o, d < lim}, {1'b1, p, oe, 1'b1});
      $display("clear test done");
   endtask

   // Forty cycles span four whole periods, so the active count is exact at any phase.
   task automatic pwm(input logic [7:0] c1, du, input logic fa, input logic [7:0] hi);
      logic [7:0] h;
      setup(8'h18, c1, du, 8'd10);
      cyc(12);
      h = 8'h00;
      repeat (40) begin
         cyc(1);
         h = h + timer_io_pin_o;
      end
      chk({match_a_flag_o, match_p_flag_o, h}, {fa, 1'b1, hi});
      $display("pwm test done");
   endtask

   task automatic t_pause;
      logic [7:0] a, b;
      setup(8'h18, 8'hc0, 8'h08, 8'h00);
      wr(4'h0, 8'h98);
      rd(4'h2, a);
      cyc(5);
      rd(4'h2, b);
      chk(b, a);
      wr(4'h0, 8'h18);
      cyc(2);
      rd(4'h2, b);
      chk(b - a > 8'h00 && b - a < 8'h08, 1'b1);
      wr(4'h0, 8'h10);
      rd(4'h2, a);
      cyc(5);
      rd(4'h2, b);
      chk(b, a);
      wr(4'h0, 8'h18);
      rd(4'h2, b);
      chk(b < 8'h04, 1'b1);
      $display("pause test done");
   endtask

   // Two reads 64 cycles apart give the count gained under each clock choice.
   task automatic t_clk;
      logic [7:0] a, b;
      logic [7:0] ex [0:7] = '{8'd16, 8'd64, 8'd4, 8'd1, 8'd32, 8'd64, 8'd8, 8'd8};
      for (int k = 0; k < 8; k++) begin
         setup({1'b0, k[2:0], 4'h8}, 8'hc0, 8'h08, 8'h00);
         cyc(8);
         rd(4'h2, a);
         cyc(62);
         rd(4'h2, b);
         chk(b - a, ex[k]);
      end
      $display("clock select test done");
   endtask

   // Capture mode: the source bit picks which pin's rising edge loads the duty value.
   task automatic t_cap;
      setup(8'h18, 8'h40, 8'h00, 8'h00);
      cyc(30);
      chk({match_a_flag_o, timer_io_pin_oe_o}, 2'h0);
      @(posedge clk_i);
      timer_io_pin_i <= 1'b1;
      cyc(10);
      chk({match_a_flag_o, timer_io_pin_oe_o}, 2'h2);
      setup(8'h18, 8'h42, 8'h00, 8'h00);
      cyc(30);
      chk({match_a_flag_o, timer_io_pin_oe_o}, 2'h2);
      $display("capture test done");
   endtask

   // Single pulse: the count pin starts the pulse and the duty match ends it.
   task automatic t_spl;
      setup(8'h10, 8'hb8, 8'h08, 8'h00);
      cyc(40);
      chk({match_a_flag_o, match_p_flag_o, timer_io_pin_oe_o}, 3'h5);
      wr(4'h1, 8'h00);
      $display("single pulse test done");
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence after 20 cycles of reset.
   initial begin
      cyc(20);
      rst_b_i <= 1'b1;
      t_regs;
      t_cmp;
      clr(8'h00, 8'd20, 1'b1, 1'b1, 8'd20);
      clr(8'h01, 8'd4, 1'b0, 1'b1, 8'd8);
      clr(8'hc0, 8'd20, 1'b1, 1'b0, 8'd20);
      pwm(8'ha8, 8'd4, 1'b1, 8'd16);
      pwm(8'ha8, 8'd12, 1'b0, 8'd40);
      pwm(8'hac, 8'd4, 1'b1, 8'd24);
      pwm(8'ha0, 8'd4, 1'b1, 8'd24);
      pwm(8'h98, 8'd4, 1'b1, 8'd40);
      pwm(8'h88, 8'd4, 1'b1, 8'd0);
      t_pause;
      t_cap;
      t_spl;
      t_clk;
      report_and_stop;
   end

   // Watchdog: the tests need about 1850 cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      report_and_stop;
   end
endmodule
`default_nettype wire
